/* File: core/startup_fault_sequencer.sv */
// startup and fault sequencer of a buck-boost regulator, with axi4-lite registers
// assumes analog comparators and pins sampled synchronously to aclk
//
// Overview of operation
// - enable powers bias, wait 100 us
// - read select resistor 450 us before soft-start
// - half current ceiling during soft-start
// - soft-start ends at target, ceiling restored
// - 100 us transition then skip-mode control
// - forced fixed switching throughout soft-start
// - 4 ms soft-start timeout latches off
// - switching stopped means discharge switch closed, except on a sense gap stop
// - latch on heat, timeout, ceiling, undervoltage
// - restart only after fault clear and enable toggle
// - heat trip, re-enable after cooling hysteresis
// - block operation below falling input threshold
// - start needs input above rise and enable
// - cycle ceiling per option 3.6 or 4.4
// - ceiling held 2 ms latches off
// - ceiling released early clears timer
// - sense gap over 0.5V stops switches
// - sense over 20 or 10 percent shuts off
// - mode select high fixed, low skip
// - output good driven low within 10 percent
// - discharge open from soft-start on while enabled and unfaulted
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module startup_fault_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned BIAS_CYC    = BIAS_SETTLE_CYC,
  parameter int unsigned READ_CYC    = RESISTOR_READ_CYC,
  parameter int unsigned TRANS_CYC   = TRANSITION_CYC,
  parameter int unsigned SOFT_CYC    = SOFTSTART_LIMIT_CYC,
  parameter int unsigned CEILING_CYC = CEILING_HOLD_CYC,
  parameter bit          HAS_MODE_PIN = 1'b1
) (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write address
  input  wire logic [3:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read address
  input  wire logic [3:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // pins and comparators
  input  wire logic                  enable_pin,
  input  wire logic                  forced_fixed_switching_select,
  input  wire seq_pkg::comp_t        comp,
  input  wire logic [5:0]            level_code,
  // power stage control
  output seq_pkg::power_ctl_t        power_ctl,
  output logic                       high_ceiling_sel,
  output logic [5:0]                 level_r,
  output logic                       output_good_flag_o,
  output logic                       output_good_flag_oe
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (BIAS_CYC < 1 || READ_CYC < 1 || TRANS_CYC < 1 || SOFT_CYC < 1 || CEILING_CYC < 1 ||
      SOFT_CYC >= (1 << CNT_W) || CEILING_CYC >= (1 << CNT_W) ||
      READ_CYC >= (1 << CNT_W)) begin : g_bad
    $error("counts out of range");
  end

  // ---------------------------------------------------------------
  // registers and bus
  // ---------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [3:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  status_t     status;
  logic        enable;
  logic        mode_fixed;

  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      awaddr_r <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (aw_got_r && w_got_r) begin
      aw_got_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_r <= 1'b0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (aw_got_r && w_got_r) begin
      w_got_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r       <= CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (aw_got_r && w_got_r) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_r[3:2] == CTRL_OFS[3:2]) begin
        s_axi_bresp <= RESP_OKAY;
        if (wstrb_r[0]) begin
          ctrl_r[7:0] <= {5'h0, wdata_r[2:0]};
        end
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr[3:2])
        CTRL_OFS[3:2]:   s_axi_rdata <= ctrl_r;
        STATUS_OFS[3:2]: s_axi_rdata <= {25'h0, status};
        LEVEL_OFS[3:2]:  s_axi_rdata <= {26'h0, level_r};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // enable pin or software enable; mode pin, or software mode when HAS_MODE_PIN is 0
  assign enable     = enable_pin || ctrl_r[CTRL_EN_BIT];
  assign mode_fixed = HAS_MODE_PIN ? forced_fixed_switching_select
                                   : ctrl_r[CTRL_MODE_BIT];
  assign high_ceiling_sel = ctrl_r[CTRL_OPT_BIT];

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  seq_state_t      state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] ceil_cnt_r;
  logic            hot_r;
  logic            enable_prev_r;
  logic [2:0]      fault_r;
  logic            over_trip;
  logic            ceil_trip;
  logic            latch_fault;
  logic            active;

  // margin shrinks for targets above 5 v
  assign over_trip = comp.target_above_5v ? comp.sense_over_10 : comp.sense_over_20;
  assign ceil_trip = ceil_cnt_r >= CNT_W'(CEILING_CYC - 1) && comp.ceiling_hit;
  assign active    = state_r == ST_SOFT || state_r == ST_TRANS || state_r == ST_RUN;
  assign latch_fault = active && (hot_r || comp.input_below_fall || ceil_trip || over_trip ||
                       (state_r == ST_SOFT && cnt_r >= CNT_W'(SOFT_CYC - 1) &&
                        !comp.out_at_target));

  // thermal trip with hysteresis
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hot_r <= 1'b0;
    end else if (comp.die_hot) begin
      hot_r <= 1'b1;
    end else if (comp.die_cooled) begin
      hot_r <= 1'b0;
    end
  end

  // ceiling hold timer, cleared when ceiling releases
  always_ff @(posedge aclk) begin
    if (!aresetn || !active || !comp.ceiling_hit) begin
      ceil_cnt_r <= '0;
    end else if (!ceil_trip) begin
      ceil_cnt_r <= ceil_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_prev_r <= 1'b0;
    end else begin
      enable_prev_r <= enable;
    end
  end

  // interval counters on aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      fault_r <= 3'h0;
      level_r <= 6'h0;
    end else if (state_r != ST_LATCH && !enable) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
    end else if (latch_fault) begin
      state_r <= ST_LATCH;
      cnt_r   <= '0;
      fault_r <= hot_r ? 3'h1 : comp.input_below_fall ? 3'h2 : ceil_trip ? 3'h3 :
                 over_trip ? 3'h4 : 3'h5;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      case (state_r)
        ST_IDLE: begin
          cnt_r <= '0;
          if (enable && comp.input_above_rise && !comp.input_below_fall && !hot_r) begin
            state_r <= ST_BIAS;
            fault_r <= 3'h0;
          end
        end
        ST_BIAS: begin
          if (cnt_r >= CNT_W'(BIAS_CYC - 1)) begin
            state_r <= ST_READ;
            cnt_r   <= '0;
          end
        end
        ST_READ: begin
          if (cnt_r >= CNT_W'(READ_CYC - 1)) begin
            state_r <= ST_SOFT;
            level_r <= level_code;
            cnt_r   <= '0;
          end
        end
        ST_SOFT: begin
          if (comp.out_at_target) begin
            state_r <= ST_TRANS;
            cnt_r   <= '0;
          end
        end
        ST_TRANS: begin
          if (cnt_r >= CNT_W'(TRANS_CYC - 1)) begin
            state_r <= ST_RUN;
            cnt_r   <= '0;
          end
        end
        ST_RUN: begin
          cnt_r <= '0;
        end
        ST_LATCH: begin
          cnt_r <= '0;
          // fresh enable rise with faults gone
          if (enable && !enable_prev_r && !hot_r && !comp.input_below_fall &&
              !over_trip && comp.input_above_rise) begin
            state_r <= ST_BIAS;
            fault_r <= 3'h0;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // power stage outputs
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_ctl <= '{discharge_on: 1'b1, default: 1'b0};
    end else begin
      power_ctl.bias_on      <= state_r != ST_IDLE && state_r != ST_LATCH;
      power_ctl.read_level   <= state_r == ST_READ;
      // gap trip stops all switches at once
      power_ctl.switching    <= active && !latch_fault && enable && !comp.sense_gap_high;
      power_ctl.forced_fixed <= state_r == ST_SOFT || state_r == ST_TRANS ||
                                mode_fixed;
      power_ctl.half_ceiling <= state_r == ST_SOFT;
      power_ctl.discharge_on <= !(active && !latch_fault && enable);
    end
  end

  // open-drain output good, pulls low inside the window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_good_flag_oe <= 1'b0;
    end else begin
      output_good_flag_oe <= active && comp.out_within_10;
    end
  end
  assign output_good_flag_o = 1'b0;

  assign status = '{fault: fault_r, latched: state_r == ST_LATCH, state: state_r};

endmodule : startup_fault_sequencer

/* File: core/seq_pkg.sv */
// package for the buck-boost startup and fault sequencer
// assumes a 100 MHz aclk; comparator inputs synchronous to aclk
package seq_pkg;

  // ---------------------------------------------------------------
  // clock and times
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS       = 10;
  localparam int unsigned BIAS_SETTLE_US      = 100;
  localparam int unsigned RESISTOR_READ_US    = 450;
  localparam int unsigned TRANSITION_US       = 100;
  localparam int unsigned SOFTSTART_LIMIT_US  = 4000;
  localparam int unsigned CEILING_HOLD_US     = 2000;
  localparam int unsigned BIAS_SETTLE_CYC     = BIAS_SETTLE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned RESISTOR_READ_CYC   = RESISTOR_READ_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TRANSITION_CYC      = TRANSITION_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SOFTSTART_LIMIT_CYC = SOFTSTART_LIMIT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned CEILING_HOLD_CYC    = CEILING_HOLD_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned CNT_W               = 20;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0]  CTRL_OFS   = 4'h0;
  localparam logic [3:0]  STATUS_OFS = 4'h4;
  localparam logic [3:0]  LEVEL_OFS  = 4'h8;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_MODE_BIT = 1;
  localparam int unsigned CTRL_OPT_BIT  = 2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // states and carriers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_BIAS, ST_READ, ST_SOFT, ST_TRANS, ST_RUN, ST_LATCH
  } seq_state_t;

  typedef struct packed {
    logic input_above_rise;
    logic input_below_fall;
    logic die_hot;
    logic die_cooled;
    logic ceiling_hit;
    logic out_at_target;
    logic out_above_90;
    logic out_within_10;
    logic sense_gap_high;
    logic sense_over_20;
    logic sense_over_10;
    logic target_above_5v;
  } comp_t;

  typedef struct packed {
    logic bias_on;
    logic read_level;
    logic switching;
    logic forced_fixed;
    logic half_ceiling;
    logic discharge_on;
  } power_ctl_t;

  typedef struct packed {
    logic [2:0] fault;
    logic       latched;
    logic [2:0] state;
  } status_t;

endpackage : seq_pkg

/* File: testbench/host_pin_model.sv */
// host side of the enable and mode pins
// assumes the bench calls its tasks right after a rising aclk edge
`timescale 1ns/100ps
module host_pin_model (
  // clock
  input  wire logic aclk,
  // pins
  output logic      enable_pin,
  output logic      forced_fixed_switching_select
);
  initial begin
    enable_pin                    = 1'b0;
    forced_fixed_switching_select = 1'b0;
  end
  // enable level, dropped and raised to restart a latched device
  task automatic drive_en(input logic v);
    enable_pin <= v;
  endtask : drive_en
  // high for fixed switching, low for skip
  task automatic drive_mode(input logic v);
    forced_fixed_switching_select <= v;
  endtask : drive_mode
endmodule : host_pin_model

/* File: testbench/seq_monitor.sv */
// assertions on the sequencer top ports
// assumes one clock aclk and sync active-low aresetn
`timescale 1ns/100ps
module seq_monitor
  import seq_pkg::*;
#(
  parameter int unsigned BIAS_CYC = 8, READ_CYC = 12, TRANS_CYC = 6,
  parameter int unsigned SOFT_CYC = 40, CEILING_CYC = 20
) (
  // clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // pins and comparators
  input wire logic                enable_pin,
  input wire logic                forced_fixed_switching_select,
  input wire seq_pkg::comp_t      comp,
  // outputs
  input wire seq_pkg::power_ctl_t power_ctl,
  input wire logic                output_good_flag_oe
);
  int bc_r, rc_r, ec_r, sc_r, hc_r;
  // ---------------------------------------------------------------
  // interval counters
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !power_ctl.bias_on || power_ctl.read_level || power_ctl.switching) bc_r <= 0;
    else bc_r <= bc_r + 1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !power_ctl.read_level || power_ctl.switching) rc_r <= 0;
    else rc_r <= rc_r + 1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || power_ctl.half_ceiling || power_ctl.read_level) ec_r <= 0;
    else if (power_ctl.switching) ec_r <= ec_r + 1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !power_ctl.half_ceiling || !power_ctl.switching) sc_r <= 0;
    else sc_r <= sc_r + 1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !comp.ceiling_hit || !power_ctl.switching) hc_r <= 0;
    else hc_r <= hc_r + 1;
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bias_settle: assert property ($rose(power_ctl.read_level) |-> bc_r == BIAS_CYC)
    else $error("bias interval wrong");
  a_read_time: assert property ($rose(power_ctl.switching) && power_ctl.half_ceiling
    |-> rc_r == READ_CYC)
    else $error("read interval wrong");
  a_soft_fixed: assert property (power_ctl.switching && power_ctl.half_ceiling
    |-> power_ctl.forced_fixed)
    else $error("soft-start not fixed");
  a_target_ends: assert property (power_ctl.half_ceiling && comp.out_at_target
    |-> ##[1:3] !power_ctl.half_ceiling)
    else $error("ceiling not restored");
  a_trans_fixed: assert property (power_ctl.switching && !power_ctl.half_ceiling
    && ec_r < TRANS_CYC - 1 |-> power_ctl.forced_fixed)
    else $error("skip before transition end");
  a_mode_follow: assert property (power_ctl.switching && ec_r > TRANS_CYC + 2
    && $stable(forced_fixed_switching_select)
    |-> power_ctl.forced_fixed == $past(forced_fixed_switching_select))
    else $error("mode pin not followed");
  a_soft_limit: assert property (sc_r == SOFT_CYC + 3 |-> !power_ctl.switching)
    else $error("no soft-start timeout");
  a_ceiling_hold: assert property (hc_r == CEILING_CYC + 3 |-> !power_ctl.switching)
    else $error("no ceiling latch");
  a_gap_stop: assert property (comp.sense_gap_high |-> ##[1:2] !power_ctl.switching)
    else $error("sense gap ignored");
  a_heat_stop: assert property (comp.die_hot |-> ##[1:2] !power_ctl.switching)
    else $error("heat ignored");
  a_low_supply: assert property (comp.input_below_fall |-> ##[1:2] !power_ctl.switching)
    else $error("low supply ignored");
  a_disable_idle: assert property (!enable_pin [*3]
    |-> !power_ctl.switching && power_ctl.discharge_on)
    else $error("disable not idle");
  a_run_open: assert property (power_ctl.switching |-> !power_ctl.discharge_on)
    else $error("discharge while running");
  a_good_drive: assert property (comp.out_within_10 && power_ctl.switching
    |-> ##[1:2] output_good_flag_oe)
    else $error("good flag not driven");
  c_soft: cover property ($rose(power_ctl.half_ceiling));
  c_stop: cover property ($fell(power_ctl.switching) && power_ctl.discharge_on);
  c_good: cover property (output_good_flag_oe);
endmodule : seq_monitor

bind startup_fault_sequencer seq_monitor #(
  .BIAS_CYC(BIAS_CYC), .READ_CYC(READ_CYC), .TRANS_CYC(TRANS_CYC),
  .SOFT_CYC(SOFT_CYC), .CEILING_CYC(CEILING_CYC)
) seq_monitor_inst (
  .aclk(aclk), .aresetn(aresetn), .enable_pin(enable_pin),
  .forced_fixed_switching_select(forced_fixed_switching_select), .comp(comp),
  .power_ctl(power_ctl), .output_good_flag_oe(output_good_flag_oe)
);

/* File: testbench/buck_boost_startup_fault_sequencer_tb_top.sv */
// bench for the startup and fault sequencer
// assumes seq_pkg, host_pin_model and seq_monitor compiled first
`timescale 1ns/100ps
module buck_boost_startup_fault_sequencer_tb_top;
  import seq_pkg::*;
  localparam int unsigned BC = 8, RC = 12, TC = 6, SC = 40, CC = 20;
  localparam comp_t BASE = 12'h900; // above rise, cooled
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        enable_pin, forced_fixed_switching_select, high_ceiling_sel;
  logic        output_good_flag_o, output_good_flag_oe;
  logic [5:0]  level_code = 6'h2a, level_r;
  comp_t       comp = BASE;
  power_ctl_t  power_ctl;
  int          err_count = 0, samples_checked = 0;
  logic [2:0]  fc [4] = '{3'h1, 3'h2, 3'h4, 3'h4};

  startup_fault_sequencer #(.BIAS_CYC(BC), .READ_CYC(RC), .TRANS_CYC(TC), .SOFT_CYC(SC),
    .CEILING_CYC(CC)) startup_fault_sequencer_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .enable_pin, .forced_fixed_switching_select, .comp, .level_code,
    .power_ctl, .high_ceiling_sel, .level_r, .output_good_flag_o, .output_good_flag_oe);
  host_pin_model host_pin_model_inst (.aclk, .enable_pin, .forced_fixed_switching_select);

  initial begin
    forever #5 aclk = ~aclk;
  end
  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic ck(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : ck
  task automatic ckb(input logic g, e);
    ck({31'h0, g}, {31'h0, e});
  endtask : ckb
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic st(input logic [6:0] e, m);
    logic [31:0] d;
    logic [1:0]  r;
    rd(STATUS_OFS, d, r);
    ck(d & {25'h0, m}, {25'h0, e});
  endtask : st
  // ---------------------------------------------------------------
  // sequence helpers
  // ---------------------------------------------------------------
  task automatic toggle();
    host_pin_model_inst.drive_en(1'b0);
    cyc(4);
    host_pin_model_inst.drive_en(1'b1);
  endtask : toggle
  task automatic wait_sw();
    int n;
    n = 0;
    while (power_ctl.switching !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    ckb(power_ctl.switching, 1'b1);
  endtask : wait_sw
  task automatic bring_up();
    comp.out_at_target <= 1'b0;
    wait_sw();
    ckb(power_ctl.half_ceiling, 1'b1);
    ckb(power_ctl.forced_fixed, 1'b1);
    comp.out_at_target <= 1'b1;
    cyc(3);
    ckb(power_ctl.half_ceiling, 1'b0);
    cyc(TC + 4);
    ckb(power_ctl.forced_fixed, 1'b0);
    st(7'h05, 7'h0f);
  endtask : bring_up
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    cyc(5);
    aresetn <= 1'b1;
    cyc(1);
    ck({26'h0, power_ctl}, 32'h1);
    wr(CTRL_OFS, 32'h6, r);
    ck({30'h0, r}, {30'h0, RESP_OKAY});
    rd(CTRL_OFS, d, r);
    ck(d, 32'h6);
    ckb(high_ceiling_sel, 1'b1);
    wr(STATUS_OFS, 32'h1, r);
    ck({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(4'hc, d, r);
    ck({d[29:0], r}, {30'h0, RESP_SLVERR});
    wr(CTRL_OFS, 32'h0, r);
    s_axi_wstrb <= 4'h0;
    wr(CTRL_OFS, 32'h4, r);
    s_axi_wstrb <= 4'hf;
    ckb(high_ceiling_sel, 1'b0);
    comp.input_above_rise <= 1'b0;
    host_pin_model_inst.drive_en(1'b1);
    cyc(20);
    st(7'h00, 7'h0f);
    comp.input_above_rise <= 1'b1;
    bring_up();
    rd(LEVEL_OFS, d, r);
    ck(d, 32'h2a);
    ck({26'h0, level_r}, 32'h2a);
    host_pin_model_inst.drive_mode(1'b1);
    cyc(3);
    ckb(power_ctl.forced_fixed, 1'b1);
    host_pin_model_inst.drive_mode(1'b0);
    comp.out_within_10 <= 1'b1;
    cyc(3);
    ckb(power_ctl.forced_fixed, 1'b0);
    ck({30'h0, output_good_flag_oe, output_good_flag_o}, 32'h2);
    comp.out_within_10 <= 1'b0;
    comp.sense_gap_high <= 1'b1;
    cyc(3);
    ckb(power_ctl.switching, 1'b0);
    comp.sense_gap_high <= 1'b0;
    cyc(3);
    ckb(power_ctl.switching, 1'b1);
    comp.ceiling_hit <= 1'b1;
    comp.sense_over_10 <= 1'b1;
    cyc(CC - 5);
    comp.ceiling_hit <= 1'b0;
    cyc(3);
    comp.ceiling_hit <= 1'b1;
    cyc(CC - 5);
    comp.ceiling_hit <= 1'b0;
    comp.sense_over_10 <= 1'b0;
    cyc(3);
    st(7'h05, 7'h0f);
    comp.ceiling_hit <= 1'b1;
    cyc(CC + 5);
    comp.ceiling_hit <= 1'b0;
    st(7'h3e, 7'h7f);
    ckb(power_ctl.discharge_on, 1'b1);
    cyc(5);
    st(7'h0e, 7'h0f);
    level_code <= 6'h15;
    toggle();
    bring_up();
    rd(LEVEL_OFS, d, r);
    ck(d, 32'h15);
    for (int i = 0; i < 4; i++) begin
      case (i)
        0: begin
          comp.die_hot <= 1'b1;
          comp.die_cooled <= 1'b0;
        end
        1: comp.input_below_fall <= 1'b1;
        2: comp.sense_over_20 <= 1'b1;
        default: begin
          comp.target_above_5v <= 1'b1;
          comp.sense_over_10 <= 1'b1;
        end
      endcase
      cyc(4);
      st({fc[i], 4'he}, 7'h7f);
      ckb(power_ctl.discharge_on, 1'b1);
      toggle();
      cyc(4);
      st(7'h0e, 7'h0f);
      comp <= BASE;
      toggle();
      bring_up();
    end
    comp <= BASE;
    toggle();
    wait_sw();
    cyc(SC + 5);
    st(7'h5e, 7'h7f);
    toggle();
    cyc(BC + 3);
    host_pin_model_inst.drive_en(1'b0);
    cyc(3);
    ck({26'h0, power_ctl}, 32'h1);
    st(7'h00, 7'h0f);
    wrap_up();
  end
  initial begin
    #400000;
    err_count++;
    wrap_up();
  end
endmodule : buck_boost_startup_fault_sequencer_tb_top
